// ---- hdl/oss_defines.svh ----
// timing counts and encodings for the on/off switch cycle controller
`ifndef OSS_DEFINES_SVH
`define OSS_DEFINES_SVH
// core clock rate in khz, 250 mhz
`define OSS_CLK_KHZ 250000
// switching oscillator average rate in khz
`define OSS_OSC_KHZ 132
// core clocks per oscillator cycle, rounded down
`define OSS_OSC_DIV (`OSS_CLK_KHZ / `OSS_OSC_KHZ)
// maximum duty on-time in core clocks, a fraction of the cycle
`define OSS_DMAX_CLKS ((`OSS_OSC_DIV * 65) / 100)
// leading edge blanking time in ns
`define OSS_BLANK_NS 200
`define OSS_BLANK_CLKS ((`OSS_BLANK_NS * 250 + 999) / 1000)
// fault timeout and restart-off period in ms
`define OSS_FAULT_MS 50
`define OSS_OFF_MS 850
// counts in oscillator cycles
`define OSS_FAULT_CYC (`OSS_FAULT_MS * `OSS_OSC_KHZ)
`define OSS_OFF_CYC (`OSS_OFF_MS * `OSS_OSC_KHZ)
// current limit level codes, 3 is full limit
`define OSS_LIM_FULL 2'h3
`define OSS_LIM_LOWEST 2'h0
`endif

// ---- hdl/oss_pkg.sv ----
// types for the on/off switch cycle controller
package oss_pkg;
  // auto-restart supervisor states
  typedef enum logic [1:0]
  {
    OSS_ST_WAIT = 2'b00,
    OSS_ST_RUN = 2'b01,
    OSS_ST_OFF = 2'b10
  } oss_state_t;
endpackage : oss_pkg

// ---- hdl/oss_sync.sv ----
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module oss_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta; // first stage, read only by second
  // ****************************************
  // two stages, nothing else looks at meta
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : oss_sync
`default_nettype wire

// ---- hdl/oss_ctrl.sv ----
// cycle-by-cycle on/off switching controller core
`timescale 1ns/1ps
`default_nettype none
`include "oss_defines.svh"
// Functional notes
// - over-current ends pulse for rest of cycle
// - lower current limit stepwise at lighter load
// - blank over-current comparator after turn-on
// - fault counter cleared when enable low while running
// - 50 ms without low: off 850 ms
// - alternate on and off while fault persists
// - under-voltage freezes restart off counter
// - start only with line current above 50uA, or below 2uA with no line resistor
// - tiny line current disables under-voltage function
// - turn switch on at cycle start
// - off at current limit or max duty
// - a started cycle completes unless supply is lost
// - enable high runs cycle, limit by load
// - free oscillator gives cycle clock, max duty
// - sample enable only at cycle start
// - supply undervoltage 4.8 V off, 5.8 V on
module oss_ctrl #(
  parameter int OSC_DIV = `OSS_OSC_DIV,
  parameter int DMAX_CLKS = `OSS_DMAX_CLKS,
  parameter int BLANK_CLKS = `OSS_BLANK_CLKS,
  parameter int FAULT_CYC = `OSS_FAULT_CYC,
  parameter int OFF_CYC = `OSS_OFF_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // analog comparator levels, asynchronous
  input wire logic enable_undervoltage_input, // high: < 240uA drawn
  input wire logic line_above_50ua, // line sense current > 50uA
  input wire logic line_above_2ua, // line resistor present
  input wire logic supply_above_5v8, // internal supply high threshold
  input wire logic supply_above_4v8, // internal supply low threshold
  // one comparator per current limit level, bit i trips at level i
  input wire logic [3:0] over_current,
  // power switch gate and status
  output logic switch_on,
  output logic [1:0] current_limit_level,
  output logic max_duty_signal,
  output logic cycle_start,
  output logic restart_off
);
  // ****************************************
  // elaboration checks
  // ****************************************
  if (OSC_DIV < 8 || DMAX_CLKS >= OSC_DIV || BLANK_CLKS >= DMAX_CLKS)
    $error("oss_ctrl: bad cycle timing parameters");
  if (FAULT_CYC < 2 || OFF_CYC < 2)
    $error("oss_ctrl: bad restart counts");

  localparam int PW = $clog2(OSC_DIV);
  localparam int FW = $clog2(FAULT_CYC > OFF_CYC ? FAULT_CYC : OFF_CYC) + 1;

  // ****************************************
  // synchronised inputs
  // ****************************************
  logic [8:0] raw_in; // all pin levels together
  logic [8:0] syn_in; // after two flops
  assign raw_in = {over_current, supply_above_4v8, supply_above_5v8,
    line_above_2ua, line_above_50ua, enable_undervoltage_input};
  oss_sync #(.WIDTH(9)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in(raw_in),
    .sync_out(syn_in)
  );
  wire en_s = syn_in[0];
  wire line_50_s = syn_in[1];
  wire line_2_s = syn_in[2];
  wire sup_hi_s = syn_in[3];
  wire sup_lo_s = syn_in[4];
  wire [3:0] oc_s = syn_in[8:5];

  // ****************************************
  // oscillator: cycle phase counter
  // ****************************************
  logic [PW-1:0] phase; // core clocks into cycle
  wire cyc_end = (phase == PW'(OSC_DIV - 1));
  wire [PW-1:0] next_phase = cyc_end ? '0 : phase + 1'b1;
  wire next_dmax = (next_phase < PW'(DMAX_CLKS)); // on-time window
  // free running, never gated
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      phase <= '0;
    else
      phase <= next_phase;
  end

  // ****************************************
  // supply undervoltage hysteresis
  // ****************************************
  logic supply_ok; // off below 4.8 V until 5.8 V again
  wire next_supply_ok = supply_ok ? sup_lo_s : sup_hi_s;
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      supply_ok <= 1'b0;
    else
      supply_ok <= next_supply_ok;
  end

  // ****************************************
  // line undervoltage, ignored without resistor
  // ****************************************
  wire line_uv = line_2_s && !line_50_s;
  wire line_ok = !line_uv; // start gate

  // ****************************************
  // auto-restart supervisor
  // ****************************************
  oss_pkg::oss_state_t state;
  oss_pkg::oss_state_t next_state;
  logic [FW-1:0] fcnt; // oscillator cycles, fault or off time
  logic [FW-1:0] next_fcnt;
  wire fault_done = (fcnt >= FW'(FAULT_CYC - 1));
  wire off_done = (fcnt >= FW'(OFF_CYC - 1));
  wire sample_en = en_s; // level at cycle start
  // decisions only at cycle boundary, once per oscillator cycle
  always_comb
  begin
    next_state = state;
    next_fcnt = fcnt;
    unique case (state)
      oss_pkg::OSS_ST_WAIT:
      begin
        // power-up: need supply and line
        next_fcnt = '0;
        if (supply_ok && line_ok)
          next_state = oss_pkg::OSS_ST_RUN;
      end
      oss_pkg::OSS_ST_RUN:
      begin
        if (!sample_en)
          next_fcnt = '0; // feedback active clears fault count
        else if (fault_done)
        begin
          next_state = oss_pkg::OSS_ST_OFF;
          next_fcnt = '0;
        end
        else
          next_fcnt = fcnt + 1'b1;
      end
      oss_pkg::OSS_ST_OFF:
      begin
        if (line_uv)
          next_fcnt = fcnt; // frozen while line low
        else if (off_done)
        begin
          next_state = oss_pkg::OSS_ST_RUN; // retry period
          next_fcnt = '0;
        end
        else
          next_fcnt = fcnt + 1'b1;
      end
      default:
      begin
        next_state = oss_pkg::OSS_ST_WAIT;
        next_fcnt = '0;
      end
    endcase
    if (!supply_ok)
      next_state = oss_pkg::OSS_ST_WAIT;
  end
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state <= oss_pkg::OSS_ST_WAIT;
      fcnt <= '0;
    end
    else if (cyc_end)
    begin
      state <= next_state;
      fcnt <= next_fcnt;
    end
  end

  // ****************************************
  // current limit state machine, sample history
  // ****************************************
  logic [3:0] history; // last four run_cycle decisions, bit0 newest
  logic [1:0] level; // active limit level
  logic [2:0] ones; // enabled count in history
  always_comb
  begin
    ones = 3'h0;
    for (int i = 0; i < 4; i++)
      ones = ones + {2'h0, history[i]};
  end
  // many skips mean lighter load, so lower the limit
  wire [1:0] next_level = (ones >= 3'h3) ? `OSS_LIM_FULL :
    (ones == 3'h2) ? 2'h2 : (ones == 3'h1) ? 2'h1 : `OSS_LIM_LOWEST;
  // enable-sampled and allowed to run this cycle
  wire run_cycle = sample_en && supply_ok &&
    (next_state == oss_pkg::OSS_ST_RUN);

  // ****************************************
  // pulse generation
  // ****************************************
  logic [PW-1:0] on_age; // clocks since turn-on
  wire blanked = (on_age < PW'(BLANK_CLKS));
  wire oc_trip = oc_s[level] && !blanked;
  // end on limit or duty, whichever first
  wire pulse_stop = oc_trip || !next_dmax;
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      switch_on <= 1'b0;
      on_age <= '0;
      history <= 4'h0;
      level <= `OSS_LIM_FULL;
      cycle_start <= 1'b0;
      max_duty_signal <= 1'b0;
    end
    else
    begin
      cycle_start <= cyc_end;
      max_duty_signal <= next_dmax;
      if (cyc_end)
      begin
        // enable looked at only here
        history <= {history[2:0], run_cycle};
        level <= next_level;
        switch_on <= run_cycle;
        on_age <= '0;
      end
      else if (switch_on)
      begin
        on_age <= on_age + 1'b1;
        // only limit, duty or supply loss end the pulse, not enable
        if (pulse_stop || !supply_ok)
          switch_on <= 1'b0; // stays off to cycle end
      end
    end
  end

  // ****************************************
  // registered status outputs
  // ****************************************
  // follow the state on the very edge it moves, so the off flag never
  // overlaps the first pulse after a retry
  wire next_restart_off = cyc_end ? (next_state == oss_pkg::OSS_ST_OFF) :
    (state == oss_pkg::OSS_ST_OFF);
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      current_limit_level <= `OSS_LIM_FULL;
      restart_off <= 1'b0;
    end
    else
    begin
      current_limit_level <= level;
      restart_off <= next_restart_off;
    end
  end
  // the feedback side owns regulation; we only sample it
endmodule : oss_ctrl
`default_nettype wire

// ---- verif/oss_ctrl_monitor.sv ----
// checker for the on/off switch cycle controller ports
`timescale 1ns/1ps
`default_nettype none
module oss_ctrl_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // levels
  input wire logic supply_above_4v8,
  input wire logic [3:0] over_current,
  // outputs under watch
  input wire logic switch_on,
  input wire logic [1:0] current_limit_level,
  input wire logic max_duty_signal,
  input wire logic cycle_start,
  input wire logic restart_off
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_start;
    $rose(switch_on) |-> cycle_start;
  endproperty
  a_start: assert property (p_start)
    else $error("switch rose off cycle start");
  property p_osc;
    cycle_start |=> (!cycle_start) [*8];
  endproperty
  a_osc: assert property (p_osc)
    else $error("cycle starts too close");
  property p_duty;
    $rose(switch_on) |-> ##[1:10] !switch_on;
  endproperty
  a_duty: assert property (p_duty)
    else $error("pulse past duty window");
  // a supply drop may end a pulse at once, so only with supply held
  property p_blank;
    $rose(switch_on) && $past(supply_above_4v8, 3) |=> switch_on;
  endproperty
  a_blank: assert property (p_blank)
    else $error("pulse cut inside blanking");
  property p_trip;
    $rose(switch_on) ##0 (over_current == 4'hf) [*8] |-> !switch_on;
  endproperty
  a_trip: assert property (p_trip)
    else $error("over-current did not end pulse");
  property p_off;
    restart_off |-> !switch_on;
  endproperty
  a_off: assert property (p_off)
    else $error("switching in restart off");
  property p_lvl;
    $changed(current_limit_level) |-> cycle_start || $past(cycle_start);
  endproperty
  a_lvl: assert property (p_lvl)
    else $error("limit changed mid cycle");
  // two sync flops, hysteresis flop and gate flop before the cut
  property p_supply;
    (!supply_above_4v8) [*5] |-> !switch_on;
  endproperty
  a_supply: assert property (p_supply)
    else $error("switching on low supply");
  property p_dmax;
    !max_duty_signal |-> !switch_on;
  endproperty
  a_dmax: assert property (p_dmax)
    else $error("switch on outside duty window");
endmodule : oss_ctrl_monitor
bind oss_ctrl oss_ctrl_monitor MON (.core_clk(core_clk), .resetn(resetn),
  .supply_above_4v8(supply_above_4v8), .over_current(over_current),
  .switch_on(switch_on), .current_limit_level(current_limit_level),
  .max_duty_signal(max_duty_signal),
  .cycle_start(cycle_start), .restart_off(restart_off));
`default_nettype wire

// ---- verif/oss_opto_model.sv ----
// feedback optocoupler model on the enable input
`timescale 1ns/1ps
`default_nettype none
module oss_opto_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // 0 regulate, 1 never pulls low, 2 always pulls low
  input wire logic [1:0] mode,
  // power stage view
  input wire logic switch_on,
  input wire logic cycle_start,
  // enable level seen by the block
  output logic enable_out
);
  int v; // output level in energy units
  logic sw_d; // last switch state
  // ****************
  // output voltage and feedback
  // ****************
  always @(posedge core_clk)
  begin
    sw_d <= switch_on;
    if (!resetn)
      v <= 0;
    else if (switch_on && !sw_d)
      v <= v + 3; // each pulse adds energy
    else if (cycle_start && v > 0)
      v <= v - 1; // load drains per skipped cycle
    // high below reference, low above
    enable_out <= (mode == 2'd2) ? 1'b0 : (mode == 2'd1) ? 1'b1 : (v < 8);
  end
endmodule : oss_opto_model
`default_nettype wire

// ---- verif/tb_onoff_switch_cycle_controller.sv ----
// self-checking bench for the on/off switch cycle controller
`timescale 1ns/1ps
`default_nettype none
module tb_onoff_switch_cycle_controller;
  logic core_clk = 0;
  logic resetn = 0; // active low, synchronous
  logic l50 = 1; // line current above 50ua
  logic l2 = 1; // line resistor present
  logic s58 = 1;
  logic s48 = 1;
  logic [3:0] oc = 4'h0; // over-current levels
  logic [1:0] mode = 2'd0; // partner behaviour
  logic en, sw, cs, ro, md;
  logic [1:0] lvl;
  logic ro_now = 1'b0; // restart flag seen mid-cycle
  logic [1:0] lvl_now = 2'h0; // limit level seen mid-cycle
  int fail_count = 0;
  int n_compared = 0;
  int rises, wmax, w, ron, k;
  // ****************
  // clock, design and partner
  // ****************
  initial forever #2 core_clk = ~core_clk;
  oss_ctrl #(.OSC_DIV(16), .DMAX_CLKS(10), .BLANK_CLKS(2), .FAULT_CYC(4),
    .OFF_CYC(6)) DUT (.core_clk(core_clk), .resetn(resetn),
    .enable_undervoltage_input(en), .line_above_50ua(l50),
    .line_above_2ua(l2), .supply_above_5v8(s58), .supply_above_4v8(s48),
    .over_current(oc), .switch_on(sw), .current_limit_level(lvl),
    .max_duty_signal(md), .cycle_start(cs), .restart_off(ro));
  oss_opto_model PART (.core_clk(core_clk), .resetn(resetn), .mode(mode),
    .switch_on(sw), .cycle_start(cs), .enable_out(en));
  // clocks for n oscillator cycles plus sync slack
  function automatic int f_clks(int n);
    return (n + 2) * 16;
  endfunction : f_clks
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s exp %0d got %0d", nm, e, g);
    end
  endtask : chk
  // step n clocks, count pulses, widest pulse, restart seen
  task automatic run(int n, bit rnd);
    rises = 0;
    wmax = 0;
    w = 0;
    ron = 0;
    repeat (n)
    begin
      // outputs are settled mid-cycle, look at them there
      @(negedge core_clk);
      if (sw === 1'b1 && w == 0)
        rises++;
      w = (sw === 1'b1) ? w + 1 : 0;
      if (w > wmax)
        wmax = w;
      if (ro === 1'b1)
        ron = 1;
      ro_now = ro;
      lvl_now = lvl;
      @(posedge core_clk);
      if (rnd)
        oc <= 4'($urandom);
    end
  endtask : run
  // wait bounded for restart off to end
  task automatic wait_on();
    k = 0;
    while (ro_now === 1'b1 && k < f_clks(8))
    begin
      run(1, 0);
      k++;
    end
  endtask : wait_on
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // ****************
  // watchdog and tests
  // ****************
  initial
  begin
    #(40000 * 4);
    fail_count++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(79));
    repeat (4) @(posedge core_clk);
    resetn <= 1;
    run(2000, 1);
    chk("pulses", 1, rises > 0);
    chk("width", 1, wmax <= 10);
    chk("restart", 0, ron);
    $display("test regulate done");
    run(1, 0); // let the last random drive land alone
    oc <= 4'hf; // every level trips
    run(400, 0);
    // two blanked clocks plus the cutting edge give a fixed width
    chk("trip width", 3, wmax);
    $display("test trip done");
    oc <= 4'h0;
    mode <= 2'd2;
    run(20, 0);
    run(400, 0);
    chk("held low", 0, rises);
    chk("no fault", 0, ron);
    // all skipped cycles: lowest limit code, 0
    chk("limit low", 0, lvl_now);
    $display("test pulled low done");
    mode <= 2'd1;
    run(f_clks(4), 0);
    chk("fault off", 1, ron);
    wait_on();
    chk("off ends", 0, ro_now);
    run(64, 0);
    chk("resumes", 1, rises > 0);
    $display("test fault done");
    l50 <= 0;
    run(f_clks(12), 0);
    chk("uv frozen", 1, ro_now);
    l50 <= 1;
    wait_on();
    run(64, 0);
    chk("line ok", 1, rises > 0);
    $display("test line uv done");
    mode <= 2'd0;
    l50 <= 0;
    l2 <= 0;
    run(400, 0);
    chk("no resistor", 1, rises > 0);
    $display("test no resistor done");
    s48 <= 0;
    s58 <= 0;
    run(8, 0);
    run(200, 0);
    chk("supply low", 0, rises);
    $display("test supply done");
    print_verdict();
  end
endmodule : tb_onoff_switch_cycle_controller
`default_nettype wire
